// [mmwb_addr_decode.sv]
// Purpose: cpu address decode into targets of the memory map
// Assumes: flash windows given per physical bank, 0 primary, 1 secondary
// Notes:   overlapping flash windows resolve to the primary bank
`timescale 1ns/1ps
module mmwb_addr_decode
	import mmwb_pkg::*;
(
	input  wire logic [31:0] addr,
	input  wire logic [1:0]  sram_sel,
	input  wire logic [31:0] fl_base [2],
	input  wire logic [31:0] fl_size [2],
	input  wire logic [1:0]  fl_en,
	output mmwb_region_t     region,
	output logic      [31:0] offset,
	output logic      [1:0]  bridge
);
	logic [31:0] sram_size;
	logic [31:0] bus_off;
	logic [31:0] fl_off [2];

	always_comb begin
		case (sram_sel)
			SRAM_SEL_64K: sram_size = SRAM_SIZE_64K;
			SRAM_SEL_96K: sram_size = SRAM_SIZE_96K;
			default:      sram_size = SRAM_SIZE_32K;
		endcase
		bus_off   = addr[31:28] == SB_NBUF_BASE[31:28] ? addr - SB_NBUF_BASE : addr - SB_BUF_BASE;
		fl_off[0] = addr - fl_base[0];
		fl_off[1] = addr - fl_base[1];
		region    = MMWB_RG_NONE;
		offset    = 32'h0000_0000;
		if (addr - DTCM_SRAM_BASE < sram_size) begin
			region = MMWB_RG_DTCM; // [RULE9]
			offset = addr - DTCM_SRAM_BASE;
		end else if (addr - SB_BUF_BASE < ALIAS_SPAN) begin
			region = MMWB_RG_SBUF; // [RULE7] [RULE10]
			offset = bus_off;
		end else if (addr - SB_NBUF_BASE < ALIAS_SPAN) begin
			region = MMWB_RG_SNBUF; // [RULE7] [RULE11]
			offset = bus_off;
		end else if (fl_en[0] && fl_off[0] < fl_size[0]) begin
			region = MMWB_RG_FL0; // [RULE1]
			offset = fl_off[0];
		end else if (fl_en[1] && fl_off[1] < fl_size[1]) begin
			region = MMWB_RG_FL1;
			offset = fl_off[1];
		end
		bridge[0] = (bus_off - BR0_OFS < BR_SPAN); // [RULE8]
		bridge[1] = (bus_off - BR1_OFS < BR_SPAN); // [RULE8]
	end
endmodule // mmwb_addr_decode

// [mmwb_chk.sv]
// Purpose: port assertions for mmwb_top
// Assumes: flash is only accessed while booting from the primary bank
// Notes:   bound to the top module below
`timescale 1ns/1ps
module mmwb_chk
	import mmwb_pkg::*;
(
	input wire logic        clk_sys,
	input wire logic        arst_n,
	input wire logic        cpu_we,
	input wire logic [31:0] cpu_addr,
	input wire logic        cpu_ack,
	input wire logic        cpu_err,
	input wire logic        tcm_req,
	input wire logic [31:0] tcm_addr,
	input wire logic [1:0]  fl_cs,
	input wire logic [31:0] fl_addr,
	input wire logic        sb_req,
	input wire logic        sb_we,
	input wire logic [31:0] sb_addr,
	input wire logic [1:0]  sb_bridge,
	input wire logic        sb_posted,
	input wire logic        sb_ack,
	input wire logic        dma_ack
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	a_boot_primary: assert property ($rose(|fl_cs) && cpu_addr < BOOT_WIN_SIZE
		|-> fl_cs == 2'b01 && fl_addr == cpu_addr) else $error("boot window not on primary");
	a_tcm_route: assert property ($rose(tcm_req) |-> tcm_addr == cpu_addr - DTCM_SRAM_BASE)
		else $error("tcm offset wrong");
	a_nbuf_direct: assert property (cpu_ack && cpu_we && cpu_addr[31:28] == 4'h5
		|-> $past(sb_ack) && !$past(sb_posted)) else $error("non-buffered write not direct");
	a_read_direct: assert property (cpu_ack && !cpu_we && cpu_addr[31:28] == 4'h4
		|-> $past(sb_ack) && !$past(sb_posted) && !$past(sb_we)) else $error("read queued");
	a_sb_hold: assert property (sb_req && !sb_ack |=> sb_req && $stable(sb_addr)
		&& $stable(sb_posted)) else $error("bus request dropped early");
	a_dma_direct: assert property (dma_ack |-> $past(sb_ack) && !$past(sb_posted))
		else $error("dma write posted");
	a_err_with_ack: assert property (cpu_err |-> cpu_ack) else $error("error without ack");
	a_flash_onehot: assert property ($onehot0(fl_cs)) else $error("both flash selects");
	a_bridge_sel: assert property (sb_req |-> sb_bridge == {sb_addr[31:26] == 6'h03,
		sb_addr[31:26] == 6'h02}) else $error("bridge select wrong");
	c_posted: cover property (sb_req && sb_posted && sb_ack);
	c_dma: cover property (dma_ack);
	c_err: cover property (cpu_err);
endmodule // mmwb_chk
bind mmwb_top mmwb_chk mmwb_chk_i (.clk_sys, .arst_n, .cpu_we, .cpu_addr, .cpu_ack, .cpu_err,
	.tcm_req, .tcm_addr, .fl_cs, .fl_addr, .sb_req, .sb_we, .sb_addr, .sb_bridge, .sb_posted,
	.sb_ack, .dma_ack);

// [mmwb_pkg.sv]
// Purpose: shared constants and types of the memory map and write buffer block
// Assumes: 32-bit cpu, system bus and register bus
// Notes:   register offsets are byte addresses on the register bus
package mmwb_pkg;
	localparam logic [31:0] BOOT_ADDR      = 32'h0000_0000;
	localparam logic [31:0] DTCM_SRAM_BASE = 32'h0400_0000;
	localparam logic [31:0] SB_BUF_BASE    = 32'h4000_0000;
	localparam logic [31:0] SB_NBUF_BASE   = 32'h5000_0000;
	localparam logic [31:0] ALIAS_SPAN     = 32'h1000_0000;
	localparam logic [31:0] BR0_OFS        = 32'h0800_0000;
	localparam logic [31:0] BR1_OFS        = 32'h0C00_0000;
	localparam logic [31:0] BR_SPAN        = 32'h0400_0000;
	localparam logic [31:0] SRAM_SIZE_32K  = 32'h0000_8000;
	localparam logic [31:0] SRAM_SIZE_64K  = 32'h0001_0000;
	localparam logic [31:0] SRAM_SIZE_96K  = 32'h0001_8000;
	localparam logic [1:0]  SRAM_SEL_32K   = 2'h0;
	localparam logic [1:0]  SRAM_SEL_64K   = 2'h1;
	localparam logic [1:0]  SRAM_SEL_96K   = 2'h2;
	localparam logic [31:0] BOOT_WIN_SIZE  = 32'h0000_2000;
	localparam int          FIFO_DEPTH     = 8;
	localparam int          FIFO_AW        = 3;
	localparam logic [4:0]  REG_CTRL       = 5'h00;
	localparam logic [4:0]  REG_PF_BASE    = 5'h04;
	localparam logic [4:0]  REG_PF_SIZE    = 5'h08;
	localparam logic [4:0]  REG_SF_BASE    = 5'h0C;
	localparam logic [4:0]  REG_SF_SIZE    = 5'h10;
	localparam logic [4:0]  REG_FL_EN      = 5'h14;
	localparam logic [4:0]  REG_STATUS     = 5'h18;
	localparam int          CTRL_POST_BIT  = 3;
	localparam int          CTRL_SRAM_LSB  = 4;
	localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;
	typedef enum logic [5:0] {
		MMWB_RG_NONE  = 6'b000001,
		MMWB_RG_DTCM  = 6'b000010,
		MMWB_RG_SBUF  = 6'b000100,
		MMWB_RG_SNBUF = 6'b001000,
		MMWB_RG_FL0   = 6'b010000,
		MMWB_RG_FL1   = 6'b100000
	} mmwb_region_t;
endpackage

// [mmwb_post_fifo.sv]
// Purpose: posted write queue in flip-flops
// Assumes: push and pop handshakes on clk_sys
// Notes:   entries leave strictly in order of arrival
`timescale 1ns/1ps
module mmwb_post_fifo
	import mmwb_pkg::*;
(
	input  wire logic clk_sys,
	input  wire logic arst_n,
	mmwb_wr_if.queue  q
);
	logic [67:0]        mem_reg [FIFO_DEPTH];
	logic [FIFO_AW-1:0] wr_ptr_reg;
	logic [FIFO_AW-1:0] rd_ptr_reg;
	logic [3:0]         cnt_reg;
	logic               do_push;
	logic               do_pop;

	assign q.push_ready = (cnt_reg != 4'(FIFO_DEPTH));
	assign q.pop_valid  = (cnt_reg != 4'h0);
	assign do_push      = q.push_valid & q.push_ready;
	assign do_pop       = q.pop_valid & q.pop_ready;
	assign {q.pop_addr, q.pop_data, q.pop_be} = mem_reg[rd_ptr_reg];
	assign q.count      = cnt_reg;

	always_ff @(posedge clk_sys) begin
		if (do_push) begin
			mem_reg[wr_ptr_reg] <= {q.push_addr, q.push_data, q.push_be};
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			cnt_reg    <= 4'h0;
		end else begin
			if (do_push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
			if (do_pop) rd_ptr_reg <= rd_ptr_reg + 1'b1; // [RULE20]
			if (do_push && !do_pop) cnt_reg <= cnt_reg + 4'h1;
			else if (do_pop && !do_push) cnt_reg <= cnt_reg - 4'h1;
		end
	end
endmodule // mmwb_post_fifo

// [mmwb_tgt_model.sv]
// Purpose: target with a request held until a pulsed ack
// Assumes: master drops req on the edge after ack
// Notes:   read data inverts each cycle without ack so stale data matches only every other cycle
`timescale 1ns/1ps
module mmwb_tgt_model #(
	parameter int LAT = 1
) (
	input  wire logic        clk_sys,
	input  wire logic        arst_n,
	input  wire logic        req,
	input  wire logic [31:0] addr,
	output logic             ack,
	output logic      [31:0] rdata
);
	int cnt;
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			cnt   <= 0;
			ack   <= 1'b0;
			rdata <= 32'h0;
		end else if (req && !ack && cnt >= LAT) begin
			ack   <= 1'b1;
			rdata <= addr ^ 32'hA5A5_0000;
		end else begin
			cnt   <= (req && !ack) ? cnt + 1 : 0;
			ack   <= 1'b0;
			rdata <= ~rdata;
		end
	end
endmodule // mmwb_tgt_model

// [mmwb_top.sv]
// Purpose: cpu address routing with posted system bus writes
// Assumes: cpu, dma and targets hold a request until its ack
// Notes:   config registers reached over avalon-mm; tap inputs are asynchronous
// Functional notes
// [RULE1] reset fetch at zero hits flash select zero
// [RULE2] ctrl bit 3 enables posting, resets clear
// [RULE3] posted buffered-alias writes queue, cpu continues
// [RULE4] posted write stalls while queue full
// [RULE5] non-buffered write goes direct, cpu waits
// [RULE6] reads never go through the queue
// [RULE7] bus slaves seen at two aliases
// [RULE8] bridge address is base plus offsets
// [RULE9] first sram alias goes to tcm port
// [RULE10] second sram alias is bus, postable
// [RULE11] third sram alias is bus, never posted
// [RULE12] sram size resets smallest, software enlarges
// [RULE13] dma writes to sram never posted
// [RULE14] one flash busy, other still readable
// [RULE15] default boot: primary at zero, secondary off
// [RULE16] alternate boot: secondary at zero, primary off
// [RULE17] boot choice is test-port nonvolatile bit
// [RULE18] cpu cannot write the boot bit
// [RULE19] firmware sets flash windows and enables
// [RULE20] queued writes drain in order, once each
//
// Decided for this implementation: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
module mmwb_top
	import mmwb_pkg::*;
#(
	parameter logic [1:0] SRAM_SEL_MAX = SRAM_SEL_96K
) (
	input  wire logic        clk_sys,
	input  wire logic        arst_n,
	input  wire logic        por_n,
	input  wire logic [4:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        cpu_req,
	input  wire logic        cpu_we,
	input  wire logic [31:0] cpu_addr,
	input  wire logic [31:0] cpu_wdata,
	input  wire logic [3:0]  cpu_be,
	output logic             cpu_ack,
	output logic             cpu_err,
	output logic      [31:0] cpu_rdata,
	output logic             tcm_req,
	output logic             tcm_we,
	output logic      [31:0] tcm_addr,
	output logic      [31:0] tcm_wdata,
	output logic      [3:0]  tcm_be,
	input  wire logic        tcm_ack,
	input  wire logic [31:0] tcm_rdata,
	output logic      [1:0]  fl_cs,
	output logic             fl_we,
	output logic      [31:0] fl_addr,
	output logic      [31:0] fl_wdata,
	input  wire logic        fl_ack,
	input  wire logic [31:0] fl_rdata,
	input  wire logic [1:0]  fl_busy,
	output logic             sb_req,
	output logic             sb_we,
	output logic      [31:0] sb_addr,
	output logic      [31:0] sb_wdata,
	output logic      [3:0]  sb_be,
	output logic      [1:0]  sb_bridge,
	output logic             sb_posted,
	input  wire logic        sb_ack,
	input  wire logic [31:0] sb_rdata,
	input  wire logic        dma_req,
	input  wire logic        dma_we,
	input  wire logic [31:0] dma_addr,
	input  wire logic [31:0] dma_wdata,
	input  wire logic [3:0]  dma_be,
	output logic             dma_ack,
	output logic      [31:0] dma_rdata,
	input  wire logic        tap_prog,
	input  wire logic        tap_erase,
	input  wire logic        tap_boot_alt
);
	typedef enum logic [5:0] {
		C_IDLE  = 6'b000001,
		C_SBUS  = 6'b000010,
		C_TCM   = 6'b000100,
		C_FLASH = 6'b001000,
		C_DONE  = 6'b010000,
		C_ERR   = 6'b100000
	} mmwb_cst_t;
	typedef enum logic [3:0] {
		B_IDLE = 4'b0001,
		B_FIFO = 4'b0010,
		B_CPU  = 4'b0100,
		B_DMA  = 4'b1000
	} mmwb_bst_t;

	mmwb_wr_if   wq ();
	mmwb_cst_t   cst_reg;
	mmwb_bst_t   bst_reg;
	logic [31:0] ctrl_reg;
	logic [31:0] fl_base_reg [2];
	logic [31:0] fl_size_reg [2];
	logic [1:0]  fl_en_reg;
	logic [31:0] phys_base   [2];
	logic [31:0] phys_size   [2];
	logic [1:0]  phys_en;
	logic        avs_ack_reg;
	logic [31:0] avs_rd_next;
	logic [2:0]  tap_sync_reg [3];
	logic        nv_boot_reg;
	logic        boot_alt_reg;
	logic        boot_cap_reg;
	logic        post_en;
	mmwb_region_t region;
	logic [31:0] dec_off;
	logic [1:0]  dec_bridge;
	logic [31:0] cpu_off_reg;
	logic [1:0]  cpu_bridge_reg;
	logic        cpu_take;
	logic        cpu_posted;
	logic [31:0] cpu_rdata_next;

	function automatic logic [31:0] be_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] be);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) r[8*i +: 8] = new_v[8*i +: 8];
		end
		return r;
	endfunction

	// index 0 of the flash arrays is the boot bank; the map swaps with the boot bit
	generate
		for (genvar p = 0; p < 2; p++) begin : g_phys
			assign phys_base[p] = fl_base_reg[p ^ int'(boot_alt_reg)];
			assign phys_size[p] = fl_size_reg[p ^ int'(boot_alt_reg)];
			assign phys_en[p]   = fl_en_reg[p ^ int'(boot_alt_reg)];
		end
	endgenerate

	assign post_en = ctrl_reg[CTRL_POST_BIT]; // [RULE2]

	mmwb_addr_decode u_decode (
		.addr     (cpu_addr),
		.sram_sel (ctrl_reg[CTRL_SRAM_LSB +: 2]),
		.fl_base  (phys_base),
		.fl_size  (phys_size),
		.fl_en    (phys_en),
		.region   (region),
		.offset   (dec_off),
		.bridge   (dec_bridge)
	);

	mmwb_post_fifo u_fifo (
		.clk_sys (clk_sys),
		.arst_n  (arst_n),
		.q       (wq.queue)
	);

	// register bus: one wait cycle, write lands at the edge waitrequest is low
	assign avs_waitrequest = (avs_read | avs_write) & ~avs_ack_reg;

	always_comb begin
		case (avs_address)
			REG_CTRL:    avs_rd_next = ctrl_reg;
			REG_PF_BASE: avs_rd_next = phys_base[0];
			REG_PF_SIZE: avs_rd_next = phys_size[0];
			REG_SF_BASE: avs_rd_next = phys_base[1];
			REG_SF_SIZE: avs_rd_next = phys_size[1];
			REG_FL_EN:   avs_rd_next = {30'h0, phys_en};
			REG_STATUS:  avs_rd_next = {23'h0, fl_busy, wq.count, ~wq.pop_valid,
				~wq.push_ready, boot_alt_reg};
			default:     avs_rd_next = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			avs_ack_reg  <= 1'b0;
			avs_readdata <= 32'h0000_0000;
		end else begin
			avs_ack_reg <= (avs_read | avs_write) & ~avs_ack_reg;
			if (avs_read && !avs_ack_reg) avs_readdata <= avs_rd_next;
		end
	end

	// the boot bit has no entry here: software has no way to alter it
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_reg       <= CTRL_RESET; // [RULE2] [RULE12]
			fl_base_reg[0] <= BOOT_ADDR; // [RULE15] [RULE16]
			fl_size_reg[0] <= BOOT_WIN_SIZE;
			fl_base_reg[1] <= 32'h0000_0000;
			fl_size_reg[1] <= 32'h0000_0000;
			fl_en_reg      <= 2'b01; // [RULE15] [RULE16]
		end else if (avs_write && avs_ack_reg) begin // [RULE18]
			case (avs_address)
				REG_CTRL: begin
					ctrl_reg <= be_merge(ctrl_reg, avs_writedata, avs_byteenable) &
						32'h0000_0038;
					if (avs_byteenable[0] &&
						avs_writedata[CTRL_SRAM_LSB +: 2] > SRAM_SEL_MAX) begin
						ctrl_reg[CTRL_SRAM_LSB +: 2] <= SRAM_SEL_MAX; // [RULE12]
					end
				end
				REG_PF_BASE: fl_base_reg[boot_alt_reg] <=
					be_merge(phys_base[0], avs_writedata, avs_byteenable);
				REG_PF_SIZE: fl_size_reg[boot_alt_reg] <=
					be_merge(phys_size[0], avs_writedata, avs_byteenable);
				REG_SF_BASE: fl_base_reg[~boot_alt_reg] <=
					be_merge(phys_base[1], avs_writedata, avs_byteenable);
				REG_SF_SIZE: fl_size_reg[~boot_alt_reg] <=
					be_merge(phys_size[1], avs_writedata, avs_byteenable);
				REG_FL_EN: begin
					if (avs_byteenable[0]) begin
						fl_en_reg[boot_alt_reg]  <= avs_writedata[0];
						fl_en_reg[~boot_alt_reg] <= avs_writedata[1];
					end
				end
				default: ;
			endcase
		end
	end

	// test port strobes cross from their own clock; stage 0 feeds stage 1 only
	generate
		for (genvar s = 0; s < 3; s++) begin : g_tap
			always_ff @(posedge clk_sys or negedge por_n) begin
				if (!por_n) tap_sync_reg[s] <= 3'b000;
				else if (s == 0) tap_sync_reg[s] <= {tap_prog, tap_erase, tap_boot_alt};
				else tap_sync_reg[s] <= tap_sync_reg[(s > 0) ? s - 1 : 0];
			end
		end
	endgenerate

	// survives system reset; the global reset or a test-port erase returns it to the erased state
	always_ff @(posedge clk_sys or negedge por_n) begin
		if (!por_n) begin
			nv_boot_reg <= 1'b0;
		end else if (tap_sync_reg[1][1] && !tap_sync_reg[2][1]) begin
			nv_boot_reg <= 1'b0; // [RULE17]
		end else if (tap_sync_reg[1][2] && !tap_sync_reg[2][2]) begin
			nv_boot_reg <= tap_sync_reg[1][0]; // [RULE17]
		end
	end

	// boot choice is caught once after reset so a later reprogram waits for a reset
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			boot_alt_reg <= 1'b0;
			boot_cap_reg <= 1'b0;
		end else if (!boot_cap_reg) begin
			boot_alt_reg <= nv_boot_reg; // [RULE16] [RULE17]
			boot_cap_reg <= 1'b1;
		end
	end

	// cpu side
	assign cpu_posted = cpu_we && post_en && (region == MMWB_RG_SBUF); // [RULE3] [RULE10]
	assign cpu_take   = (cst_reg == C_IDLE) && cpu_req && boot_cap_reg;
	assign wq.push_valid = cpu_take && cpu_posted; // [RULE3]
	assign wq.push_addr  = dec_off;
	assign wq.push_data  = cpu_wdata;
	assign wq.push_be    = cpu_be;
	assign cpu_ack = (cst_reg == C_DONE) || (cst_reg == C_ERR);
	assign cpu_err = (cst_reg == C_ERR);

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			cst_reg        <= C_IDLE;
			cpu_off_reg    <= 32'h0000_0000;
			cpu_bridge_reg <= 2'b00;
		end else begin
			case (cst_reg)
				C_IDLE: begin
					if (cpu_take) begin
						cpu_off_reg    <= dec_off;
						cpu_bridge_reg <= dec_bridge;
						case (region)
							MMWB_RG_DTCM: cst_reg <= C_TCM; // [RULE9]
							MMWB_RG_SBUF, MMWB_RG_SNBUF: begin
								if (!cpu_posted) cst_reg <= C_SBUS; // [RULE5] [RULE6] [RULE11]
								else if (wq.push_ready) cst_reg <= C_DONE; // [RULE3] [RULE4]
							end
							MMWB_RG_FL0, MMWB_RG_FL1: cst_reg <= C_FLASH;
							default: cst_reg <= C_ERR;
						endcase
					end
				end
				C_SBUS:  if (bst_reg == B_CPU && sb_ack) cst_reg <= C_DONE; // [RULE5]
				C_TCM:   if (tcm_ack) cst_reg <= C_DONE;
				C_FLASH: if (fl_ack && |fl_cs) cst_reg <= C_DONE;
				C_DONE, C_ERR: cst_reg <= C_IDLE;
				default: cst_reg <= C_IDLE;
			endcase
		end
	end

	always_comb begin
		cpu_rdata_next = cpu_rdata;
		if (cst_reg == C_SBUS && bst_reg == B_CPU && sb_ack) cpu_rdata_next = sb_rdata;
		else if (cst_reg == C_TCM && tcm_ack) cpu_rdata_next = tcm_rdata;
		else if (cst_reg == C_FLASH && fl_ack) cpu_rdata_next = fl_rdata;
		else if (cst_reg == C_ERR) cpu_rdata_next = 32'h0000_0000;
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) cpu_rdata <= 32'h0000_0000;
		else cpu_rdata <= cpu_rdata_next;
	end

	// tcm port
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			tcm_req   <= 1'b0;
			tcm_we    <= 1'b0;
			tcm_addr  <= 32'h0000_0000;
			tcm_wdata <= 32'h0000_0000;
			tcm_be    <= 4'h0;
		end else if (cpu_take && region == MMWB_RG_DTCM) begin
			tcm_req   <= 1'b1; // [RULE9]
			tcm_we    <= cpu_we;
			tcm_addr  <= dec_off;
			tcm_wdata <= cpu_wdata;
			tcm_be    <= cpu_be;
		end else if (tcm_ack) begin
			tcm_req <= 1'b0;
		end
	end

	// flash port: a read waits only on its own bank, the other bank stays usable
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			fl_cs    <= 2'b00;
			fl_we    <= 1'b0;
			fl_addr  <= 32'h0000_0000;
			fl_wdata <= 32'h0000_0000;
		end else if (cst_reg == C_FLASH && fl_cs == 2'b00) begin
			if (fl_we || !fl_busy[region == MMWB_RG_FL1]) begin // [RULE14]
				fl_cs <= (region == MMWB_RG_FL1) ? 2'b10 : 2'b01; // [RULE1]
			end
		end else if (cpu_take && (region == MMWB_RG_FL0 || region == MMWB_RG_FL1)) begin
			fl_we    <= cpu_we;
			fl_addr  <= dec_off;
			fl_wdata <= cpu_wdata;
		end else if (fl_ack) begin
			fl_cs <= 2'b00;
		end
	end

	// system bus: queue first so a direct access never overtakes a posted one
	assign wq.pop_ready = (bst_reg == B_FIFO) && sb_ack; // [RULE20]

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			bst_reg   <= B_IDLE;
			sb_req    <= 1'b0;
			sb_we     <= 1'b0;
			sb_addr   <= 32'h0000_0000;
			sb_wdata  <= 32'h0000_0000;
			sb_be     <= 4'h0;
			sb_bridge <= 2'b00;
			sb_posted <= 1'b0;
		end else begin
			case (bst_reg)
				B_IDLE: begin
					if (wq.pop_valid) begin
						bst_reg   <= B_FIFO; // [RULE20]
						sb_req    <= 1'b1;
						sb_we     <= 1'b1;
						sb_addr   <= wq.pop_addr;
						sb_wdata  <= wq.pop_data;
						sb_be     <= wq.pop_be;
						sb_bridge <= {wq.pop_addr - BR1_OFS < BR_SPAN,
							wq.pop_addr - BR0_OFS < BR_SPAN}; // [RULE8]
						sb_posted <= 1'b1;
					end else if (cst_reg == C_SBUS) begin
						bst_reg   <= B_CPU; // [RULE5] [RULE6]
						sb_req    <= 1'b1;
						sb_we     <= cpu_we;
						sb_addr   <= cpu_off_reg;
						sb_wdata  <= cpu_wdata;
						sb_be     <= cpu_be;
						sb_bridge <= cpu_bridge_reg;
						sb_posted <= 1'b0;
					end else if (dma_req && !dma_ack) begin
						bst_reg   <= B_DMA; // [RULE13]
						sb_req    <= 1'b1;
						sb_we     <= dma_we;
						sb_addr   <= dma_addr;
						sb_wdata  <= dma_wdata;
						sb_be     <= dma_be;
						sb_bridge <= {dma_addr - BR1_OFS < BR_SPAN, dma_addr - BR0_OFS < BR_SPAN};
						sb_posted <= 1'b0;
					end
				end
				B_FIFO, B_CPU, B_DMA: begin
					if (sb_ack) begin
						bst_reg <= B_IDLE;
						sb_req  <= 1'b0;
					end
				end
				default: bst_reg <= B_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			dma_ack   <= 1'b0;
			dma_rdata <= 32'h0000_0000;
		end else begin
			dma_ack <= (bst_reg == B_DMA) && sb_ack;
			if (bst_reg == B_DMA && sb_ack) dma_rdata <= sb_rdata;
		end
	end
endmodule // mmwb_top

// [mmwb_wr_if.sv]
// Purpose: push and pop channels of the posted write queue
// Assumes: one clock domain
// Notes:   entry is address, data and byte enables
`timescale 1ns/1ps
interface mmwb_wr_if;
	logic        push_valid;
	logic        push_ready;
	logic [31:0] push_addr;
	logic [31:0] push_data;
	logic [3:0]  push_be;
	logic        pop_valid;
	logic        pop_ready;
	logic [31:0] pop_addr;
	logic [31:0] pop_data;
	logic [3:0]  pop_be;
	logic [3:0]  count;
	modport producer (output push_valid, push_addr, push_data, push_be, pop_ready,
		input push_ready, pop_valid, pop_addr, pop_data, pop_be, count);
	modport queue (input push_valid, push_addr, push_data, push_be, pop_ready,
		output push_ready, pop_valid, pop_addr, pop_data, pop_be, count);
endinterface

// [tb.sv]
// Purpose: self-checking bench of mmwb_top
// Assumes: targets answer with their address xor a fixed pattern
// Notes:   slow bus target so the posting queue fills
`timescale 1ns/1ps
`define chk(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
	$display("unexpected %s exp %h got %h", nm, e, g); n_errors++; end end
module tb;
	import mmwb_pkg::*;
	localparam logic [31:0] K = 32'hA5A5_0000;
	logic        clk_sys = 1'b0, arst_n = 1'b0, por_n = 1'b0, err;
	logic        avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
	logic [4:0]  avs_address = 5'h00;
	logic [3:0]  avs_byteenable = 4'hF, cpu_be = 4'hF, dma_be = 4'hF, tcm_be, sb_be;
	logic        cpu_req = 1'b0, cpu_we = 1'b0, cpu_ack, cpu_err, tcm_req, tcm_we, tcm_ack;
	logic        fl_we, fl_ack, sb_req, sb_we, sb_posted, sb_ack, dma_ack;
	logic        dma_req = 1'b0, dma_we = 1'b0, tap_prog = 1'b0, tap_erase = 1'b0;
	logic        tap_boot_alt = 1'b0;
	logic [1:0]  fl_cs, sb_bridge, br, fl_busy = 2'h0;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, cpu_addr = 32'h0, cpu_wdata = 32'h0;
	logic [31:0] cpu_rdata, tcm_addr, tcm_wdata, tcm_rdata, fl_addr, fl_wdata, fl_rdata;
	logic [31:0] sb_addr, sb_wdata, sb_rdata, dma_rdata, dma_addr = 32'h0, dma_wdata = 32'h0;
	logic [31:0] rd, q;
	logic [68:0] wq[$];
	int          n, nmax, n_errors, n_compared;
	always #2.5 clk_sys = ~clk_sys;
	mmwb_top mmwb_top_i (.*);
	mmwb_tgt_model #(.LAT(0)) mmwb_tgt_model_t_i (.clk_sys, .arst_n, .req(tcm_req),
		.addr(tcm_addr), .ack(tcm_ack), .rdata(tcm_rdata));
	mmwb_tgt_model #(.LAT(2)) mmwb_tgt_model_f_i (.clk_sys, .arst_n, .req(|fl_cs),
		.addr(fl_addr), .ack(fl_ack), .rdata(fl_rdata));
	// slow on purpose: drains slower than the cpu posts
	mmwb_tgt_model #(.LAT(6)) mmwb_tgt_model_i (.clk_sys, .arst_n, .req(sb_req),
		.addr(sb_addr), .ack(sb_ack), .rdata(sb_rdata));
	always @(posedge clk_sys) begin
		if (sb_req && sb_ack && sb_we)
			wq.push_back({sb_posted, sb_be, sb_addr, sb_wdata});
		if (sb_req && sb_ack)
			br = sb_bridge;
	end
	task automatic test_done();
		if (n_errors == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic avs(input logic we, input logic [4:0] a, input logic [31:0] d);
		avs_address   <= a;
		avs_writedata <= d;
		avs_write     <= we;
		avs_read      <= !we;
		do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic cpu(input logic we, input logic [31:0] a, input logic [31:0] d);
		n = 0;
		cpu_addr  <= a;
		cpu_wdata <= d;
		cpu_we    <= we;
		cpu_req   <= 1'b1;
		do begin @(posedge clk_sys); n++; end while (cpu_ack !== 1'b1);
		rd  = cpu_rdata;
		err = cpu_err;
		cpu_req <= 1'b0;
		@(posedge clk_sys);
	endtask
	initial begin
		repeat (5000) @(posedge clk_sys);
		n_errors++;
		test_done();
	end
	initial begin
		repeat (2) @(posedge clk_sys);
		arst_n <= 1'b1;
		por_n  <= 1'b1;
		@(posedge clk_sys);
		avs(0, REG_CTRL, 32'h0);            `chk("ctrl", CTRL_RESET, q)
		avs(0, 5'h1C, 32'h0);               `chk("unmapped", 32'h0, q)
		cpu(0, BOOT_ADDR + 32'h10, 32'h0);  `chk("boot", K ^ 32'h10, rd)
		cpu(0, DTCM_SRAM_BASE + SRAM_SIZE_32K, 32'h0); `chk("size32", 1'b1, err)
		cpu(1, SB_BUF_BASE + 32'h20, 32'h11);
		`chk("nopost", {1'b0, 4'hF, 32'h20, 32'h11}, wq.pop_front())
		avs_byteenable <= 4'hE;
		avs(1, REG_CTRL, 32'hFF);
		avs_byteenable <= 4'hF;
		avs(0, REG_CTRL, 32'h0);            `chk("ctrl_be", 32'h0, q)
		avs(1, REG_CTRL, 32'hFF);
		avs(0, REG_CTRL, 32'h0);            `chk("ctrl", 32'h28, q)
		cpu(0, DTCM_SRAM_BASE + SRAM_SIZE_32K, 32'h0);
		`chk("size96", {1'b0, K ^ SRAM_SIZE_32K}, {err, rd})
		cpu_be <= 4'hC;
		cpu(1, SB_NBUF_BASE + 32'h200, 32'h22);
		`chk("nbuf", {1'b0, 4'hC, 32'h200, 32'h22}, wq.pop_front())
		cpu_be <= 4'hF;
		for (int i = 0; i < 32; i++) begin
			cpu(1, SB_BUF_BASE + 32'h100 + 4 * i, i);
			if (i == 0) `chk("fast", 2, n)
			nmax = n > nmax ? n : nmax;
		end
		`chk("stall", 1'b1, nmax > 2)
		cpu(0, SB_BUF_BASE + 32'h100, 32'h0); `chk("read", K ^ 32'h100, rd)
		for (int t = 0; t < 600 && wq.size() < 32; t++)
			@(posedge clk_sys);
		for (int i = 0; i < 32; i++)
			`chk("order", {1'b1, 4'hF, 32'h100 + 4 * i, i}, wq.pop_front())
		cpu(0, SB_NBUF_BASE + BR0_OFS + 32'h40, 32'h0); `chk("br0", 2'b01, br)
		cpu(0, SB_BUF_BASE + BR1_OFS + 32'h80, 32'h0);
		`chk("br1", {2'b10, K ^ (BR1_OFS + 32'h80)}, {br, rd})
		dma_addr  <= 32'h300;
		dma_wdata <= 32'h33;
		dma_be    <= 4'h3;
		dma_we    <= 1'b1;
		dma_req   <= 1'b1;
		do @(posedge clk_sys); while (dma_ack !== 1'b1);
		dma_req <= 1'b0;
		`chk("dma", {1'b0, 4'h3, 32'h300, 32'h33}, wq.pop_front())
		avs(1, REG_SF_BASE, 32'h4000);
		avs(1, REG_SF_SIZE, 32'h2000);
		avs(1, REG_FL_EN, 32'h3);
		avs(0, REG_SF_BASE, 32'h0); `chk("sf_base", 32'h4000, q)
		fl_busy <= 2'b01;
		cpu(0, 32'h4010, 32'h0); `chk("sf_read", K ^ 32'h10, rd)
		tap_boot_alt <= 1'b1;
		tap_prog     <= 1'b1;
		repeat (4) @(posedge clk_sys);
		arst_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		arst_n <= 1'b1;
		@(posedge clk_sys);
		avs(1, REG_STATUS, 32'h0);
		avs(0, REG_STATUS, 32'h0); `chk("alt", 32'h85, q)
		avs(0, REG_FL_EN, 32'h0); `chk("alt_en", 32'h2, q)
		avs(0, REG_CTRL, 32'h0); `chk("ctrl_rst", CTRL_RESET, q)
		test_done();
	end
endmodule // tb
